// File: ssa_pkg.sv
package ssa_pkg;
  // two bus addresses: control/status and data
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_DATA = 12'h004;

  // control 1 fields
  localparam int CR1_RX_RST = 0;
  localparam int CR1_TX_RST = 1;
  localparam int CR1_STRIP = 2;
  localparam int CR1_CLR_SYNC = 3;
  localparam int CR1_TX_IE = 4;
  localparam int CR1_RX_IE = 5;
  localparam int CR1_AC_LO = 6;
  localparam logic [7:0] CR1_RESET = 8'h03;

  // address-control codes for writes to the data address
  localparam logic [1:0] AC_CR2 = 2'h0;
  localparam logic [1:0] AC_CR3 = 2'h1;
  localparam logic [1:0] AC_SYNC = 2'h2;
  localparam logic [1:0] AC_TXD = 2'h3;

  // control 2 fields
  localparam int CR2_PAR_EN = 0;
  localparam int CR2_PAR_ODD = 1;
  localparam int CR2_TX_SYNC_UF = 2;
  localparam int CR2_SM_SEL = 3;
  localparam int CR2_DTR = 4;
  localparam int CR2_UF_IE = 5;
  localparam logic [7:0] CR2_RESET = 8'h00;

  // control 3 fields
  localparam int CR3_EXT_SYNC = 0;
  localparam int CR3_ONE_SYNC = 1;
  localparam int CR3_CLR_CTS = 2;
  localparam int CR3_CLR_UF = 3;
  localparam logic [7:0] CR3_RESET = 8'h00;
  localparam logic [7:0] SYNC_RESET = 8'h00;

  // status fields
  localparam int ST_RX_AVAIL = 0;
  localparam int ST_TX_AVAIL = 1;
  localparam int ST_CARRIER_N = 2;
  localparam int ST_CTS = 3;
  localparam int ST_UF = 4;
  localparam int ST_PERR = 6;
  localparam int ST_IRQ = 7;

  localparam logic [7:0] MARK_CHAR = 8'hFF;
  localparam logic [3:0] LAST_NOPAR = 4'h7;
  localparam logic [3:0] LAST_PAR = 4'h8;
  localparam int FIFO_DEPTH = 3;

  typedef enum {RX_HUNT, RX_WAIT2, RX_SYNCED} ssa_rx_state_t;

  typedef struct packed {
    logic perr;
    logic [7:0] data;
  } ssa_rx_word_t;
endpackage : ssa_pkg

// File: ssa_edge_sync.sv
`timescale 1ns/1ps
module ssa_edge_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic level,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } ssa_sync_state_t;
  ssa_sync_state_t st_reg, st_next;

  // only s2 reads s1; edges are found between s2 and s3
  always_comb begin
    st_next = '{s1: async_in, s2: st_reg.s1, s3: st_reg.s2};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level = st_reg.s2;
  assign rise = st_reg.s2 & ~st_reg.s3;
  assign fall = ~st_reg.s2 & st_reg.s3;
endmodule : ssa_edge_sync

// File: ssa_fifo3.sv
`timescale 1ns/1ps
module ssa_fifo3 #(
  parameter int W = 9
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic push,
  input wire logic [W-1:0] din,
  input wire logic pop,
  output logic [W-1:0] dout,
  output logic empty,
  output logic full
);
  localparam int D = ssa_pkg::FIFO_DEPTH;
  localparam logic [1:0] DEPTH_C = 2'(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [1:0] cnt;
  } ssa_fifo_state_t;
  ssa_fifo_state_t st_reg, st_next;

  // fall-through: entry 0 is the output, new words land at the first empty slot
  always_comb begin
    st_next = st_reg;
    if (pop && st_reg.cnt != 2'h0) begin
      for (int i = 0; i < D - 1; i++) begin
        st_next.mem[i] = st_reg.mem[i+1];
      end
      st_next.cnt = st_reg.cnt - 2'h1;
    end
    if (push && st_next.cnt != DEPTH_C) begin
      st_next.mem[st_next.cnt] = din;
      st_next.cnt = st_next.cnt + 2'h1;
    end
    if (flush) begin
      st_next.cnt = 2'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.mem[0];
  assign empty = (st_reg.cnt == 2'h0);
  assign full = (st_reg.cnt == DEPTH_C);
endmodule : ssa_fifo3

// File: ssa_core.sv
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module ssa_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_clk,
  output logic tx_data_out,
  input wire logic clear_to_send_n,
  input wire logic rx_clk,
  input wire logic rx_data_in,
  input wire logic carrier_detect_in_n,
  output logic sync_match_terminal_ready,
  output logic tx_underflow_out,
  output logic irq_req
);
  typedef struct packed {
    logic [7:0] cr1;
    logic [7:0] cr2;
    logic [7:0] cr3;
    logic [7:0] sync;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic tx_arm;
    logic tx_on;
    logic tx_out;
    logic uf_pulse;
    logic uf_st;
    logic [8:0] tx_sh;
    logic [8:0] tx_pend;
    logic [3:0] tx_cnt;
    ssa_pkg::ssa_rx_state_t rx_st;
    logic [7:0] rx_sh;
    logic [3:0] rx_cnt;
    logic sm;
    logic sm_out;
  } ssa_core_state_t;
  ssa_core_state_t st_reg, st_next;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction : hit

  // character with its parity bit on top
  function automatic logic [8:0] mk_char(input logic [7:0] d, input logic [7:0] cr2);
    logic p;
    p = cr2[ssa_pkg::CR2_PAR_ODD] ? ~^d : ^d;
    return {p, d};
  endfunction : mk_char

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and fifos

  logic txc_rise, txc_fall, rxc_rise, rxd_s, cts_s, carrier_n_s;
  logic tx_push, tx_pop, tx_empty, tx_full;
  logic [7:0] tx_head;
  logic rx_push, rx_pop, rx_empty, rx_full;
  ssa_pkg::ssa_rx_word_t rx_word, rx_head;

  // each serial side runs off its own sampled clock
  ssa_edge_sync u_txc (.clk(pclk), .rst_n(presetn), .async_in(tx_clk), .level(),
    .rise(txc_rise), .fall(txc_fall));
  ssa_edge_sync u_rxc (.clk(pclk), .rst_n(presetn), .async_in(rx_clk), .level(),
    .rise(rxc_rise), .fall());
  ssa_edge_sync u_rxd (.clk(pclk), .rst_n(presetn), .async_in(rx_data_in), .level(rxd_s),
    .rise(), .fall());
  ssa_edge_sync u_cts (.clk(pclk), .rst_n(presetn), .async_in(clear_to_send_n),
    .level(cts_s), .rise(), .fall());
  ssa_edge_sync u_cdet (.clk(pclk), .rst_n(presetn), .async_in(carrier_detect_in_n),
    .level(carrier_n_s), .rise(), .fall());

  // tx fifo flushed by transmitter reset only, never by clear-to-send
  ssa_fifo3 #(.W(8)) u_txf (.clk(pclk), .rst_n(presetn),
    .flush(st_reg.cr1[ssa_pkg::CR1_TX_RST]), .push(tx_push), .din(pwdata[7:0]),
    .pop(tx_pop), .dout(tx_head), .empty(tx_empty), .full(tx_full));
  ssa_fifo3 #(.W(9)) u_rxf (.clk(pclk), .rst_n(presetn),
    .flush(st_reg.cr1[ssa_pkg::CR1_RX_RST]), .push(rx_push), .din(rx_word),
    .pop(rx_pop), .dout(rx_head), .empty(rx_empty), .full(rx_full));

  ////////////////////////////////////////////////////////////////////////////
  // bus decode and status

  logic setup, acc, wr_ctrl, wr_data, rd_data, release_irq, ext, tx_run;
  logic tx_buffer_available_flag, receive_available_flag;
  logic [1:0] ac;
  logic [3:0] tx_last, rx_last;
  logic [7:0] status;

  always_comb begin
    setup = psel & ~penable;
    acc = psel & penable & st_reg.pready;
    wr_ctrl = acc & pwrite & hit(paddr, ssa_pkg::ADDR_CTRL);
    wr_data = acc & pwrite & hit(paddr, ssa_pkg::ADDR_DATA);
    rd_data = acc & ~pwrite & hit(paddr, ssa_pkg::ADDR_DATA);
    ac = st_reg.cr1[ssa_pkg::CR1_AC_LO +: 2];
    ext = st_reg.cr3[ssa_pkg::CR3_EXT_SYNC];
    // writes to a full fifo are dropped
    tx_push = wr_data & (ac == ssa_pkg::AC_TXD) & ~tx_full;
    rx_pop = rd_data;
    // clear-to-send stops the shifter but the fifo keeps its bytes
    tx_run = ~st_reg.cr1[ssa_pkg::CR1_TX_RST] & ~cts_s;
    // in external mode the fifo status stays visible for preloading
    tx_buffer_available_flag = ~tx_full & ~st_reg.cr1[ssa_pkg::CR1_TX_RST]
      & (ext | ~cts_s);
    receive_available_flag = ~rx_empty;
    tx_last = st_reg.cr2[ssa_pkg::CR2_PAR_EN] ? ssa_pkg::LAST_PAR : ssa_pkg::LAST_NOPAR;
    rx_last = tx_last;
    status = 8'h00;
    status[ssa_pkg::ST_RX_AVAIL] = receive_available_flag;
    status[ssa_pkg::ST_TX_AVAIL] = tx_buffer_available_flag;
    status[ssa_pkg::ST_CARRIER_N] = carrier_n_s;
    status[ssa_pkg::ST_CTS] = cts_s;
    status[ssa_pkg::ST_UF] = st_reg.uf_st;
    status[ssa_pkg::ST_PERR] = receive_available_flag & rx_head.perr;
    status[ssa_pkg::ST_IRQ] = st_reg.irq;
    release_irq = tx_push | rd_data
      | (wr_ctrl & (pwdata[ssa_pkg::CR1_RX_RST] | pwdata[ssa_pkg::CR1_TX_RST]))
      | (wr_data & (ac == ssa_pkg::AC_CR3)
         & (pwdata[ssa_pkg::CR3_CLR_CTS] | pwdata[ssa_pkg::CR3_CLR_UF]));
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic [8:0] c9, exp9;
  logic [7:0] rsh;
  logic rdone, rmatch, par_phase;

  always_comb begin
    st_next = st_reg;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_word = '0;
    c9 = '0;
    exp9 = '0;
    rsh = st_reg.rx_sh;
    rdone = 1'b0;
    rmatch = 1'b0;
    par_phase = 1'b0;

    // bus slave: answer one cycle after setup
    st_next.pready = setup;
    st_next.pslverr = setup & ~hit(paddr, ssa_pkg::ADDR_CTRL) & ~hit(paddr, ssa_pkg::ADDR_DATA);
    if (setup && !pwrite) begin
      st_next.prdata = 32'h0;
      if (hit(paddr, ssa_pkg::ADDR_CTRL)) begin
        st_next.prdata[7:0] = status;
      end else if (hit(paddr, ssa_pkg::ADDR_DATA)) begin
        st_next.prdata[7:0] = rx_head.data;
      end
    end
    // control 1 direct, the rest through the address-control field
    if (wr_ctrl) begin
      st_next.cr1 = pwdata[7:0];
    end
    if (wr_data) begin
      case (ac)
        ssa_pkg::AC_CR2: st_next.cr2 = pwdata[7:0];
        ssa_pkg::AC_CR3: begin
          st_next.cr3 = pwdata[7:0] & 8'h03;
          if (pwdata[ssa_pkg::CR3_CLR_UF]) begin
            st_next.uf_st = 1'b0;
          end
        end
        ssa_pkg::AC_SYNC: st_next.sync = pwdata[7:0];
        default: ;
      endcase
    end

    // transmitter
    if (!tx_run) begin
      st_next.tx_arm = 1'b0;
      st_next.tx_on = 1'b0;
      st_next.tx_out = 1'b1;
      st_next.uf_pulse = 1'b0;
    end else if (txc_rise) begin
      if (!st_reg.tx_on) begin
        st_next.tx_arm = 1'b1;
      end else if (st_reg.tx_cnt == tx_last) begin
        // next character is picked during the high half of the last bit
        if (!tx_empty) begin
          tx_pop = 1'b1;
          st_next.tx_pend = mk_char(tx_head, st_reg.cr2);
        end else begin
          st_next.tx_pend = mk_char(st_reg.cr2[ssa_pkg::CR2_TX_SYNC_UF] ?
            st_reg.sync : ssa_pkg::MARK_CHAR, st_reg.cr2);
          st_next.uf_st = 1'b1;
          st_next.uf_pulse = st_reg.cr2[ssa_pkg::CR2_TX_SYNC_UF];
        end
      end
    end else if (txc_fall) begin
      st_next.uf_pulse = 1'b0;
      if (st_reg.tx_arm && !st_reg.tx_on) begin
        // start on the fall that closes the first whole high half
        if (!tx_empty) begin
          tx_pop = 1'b1;
          c9 = mk_char(tx_head, st_reg.cr2);
        end else begin
          c9 = mk_char(st_reg.cr2[ssa_pkg::CR2_TX_SYNC_UF] ?
            st_reg.sync : ssa_pkg::MARK_CHAR, st_reg.cr2);
          st_next.uf_st = 1'b1;
        end
        st_next.tx_on = 1'b1;
        st_next.tx_sh = c9;
        st_next.tx_out = c9[0];
        st_next.tx_cnt = 4'h0;
      end else if (st_reg.tx_on) begin
        if (st_reg.tx_cnt == tx_last) begin
          st_next.tx_sh = st_reg.tx_pend;
          st_next.tx_out = st_reg.tx_pend[0];
          st_next.tx_cnt = 4'h0;
        end else begin
          st_next.tx_sh = {1'b1, st_reg.tx_sh[8:1]};
          st_next.tx_out = st_reg.tx_sh[1];
          st_next.tx_cnt = st_reg.tx_cnt + 4'h1;
        end
      end
    end

    // receiver
    if (st_reg.cr1[ssa_pkg::CR1_RX_RST]) begin
      st_next.rx_sh = 8'hFF;
      st_next.rx_st = ssa_pkg::RX_HUNT;
      st_next.rx_cnt = 4'h0;
      st_next.sm = 1'b0;
    end else if (rxc_rise) begin
      st_next.sm = 1'b0;
      par_phase = st_reg.cr2[ssa_pkg::CR2_PAR_EN] && (st_reg.rx_cnt == ssa_pkg::LAST_PAR);
      // the parity bit never enters the data shifter
      rsh = par_phase ? st_reg.rx_sh : {rxd_s, st_reg.rx_sh[7:1]};
      st_next.rx_sh = rsh;
      rdone = (st_reg.rx_cnt == rx_last);
      rmatch = (rsh == st_reg.sync);
      exp9 = mk_char(rsh, st_reg.cr2);
      rx_word.data = rsh;
      rx_word.perr = par_phase & (rxd_s != exp9[8]);
      if (st_reg.cr1[ssa_pkg::CR1_CLR_SYNC] || (ext && carrier_n_s)) begin
        st_next.rx_st = ssa_pkg::RX_HUNT;
        st_next.rx_cnt = 4'h0;
      end else if (!ext && st_reg.rx_st == ssa_pkg::RX_HUNT) begin
        // bit-by-bit search
        if (rmatch) begin
          st_next.rx_st = st_reg.cr3[ssa_pkg::CR3_ONE_SYNC] ?
            ssa_pkg::RX_SYNCED : ssa_pkg::RX_WAIT2;
          st_next.rx_cnt = 4'h0;
          st_next.sm = 1'b1;
        end
      end else begin
        st_next.rx_cnt = rdone ? 4'h0 : st_reg.rx_cnt + 4'h1;
        if (ext) begin
          st_next.rx_st = ssa_pkg::RX_SYNCED;
          rx_push = rdone;
        end else if (rdone) begin
          case (st_reg.rx_st)
            ssa_pkg::RX_WAIT2: begin
              // a miss drops back to the bit search
              st_next.rx_st = rmatch ? ssa_pkg::RX_SYNCED : ssa_pkg::RX_HUNT;
              st_next.sm = rmatch;
            end
            ssa_pkg::RX_SYNCED: begin
              rx_push = ~(st_reg.cr1[ssa_pkg::CR1_STRIP] & rmatch);
            end
            default: ;
          endcase
        end
      end
    end
    st_next.sm_out = st_reg.cr2[ssa_pkg::CR2_SM_SEL] ? st_reg.sm : ~st_reg.cr2[ssa_pkg::CR2_DTR];

    // level interrupt, dropped for one cycle by any release access
    st_next.irq = ~release_irq & ((receive_available_flag & st_reg.cr1[ssa_pkg::CR1_RX_IE])
      | (tx_buffer_available_flag & st_reg.cr1[ssa_pkg::CR1_TX_IE])
      | (st_reg.uf_st & st_reg.cr2[ssa_pkg::CR2_UF_IE]));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.cr1 <= ssa_pkg::CR1_RESET;
      st_reg.cr2 <= ssa_pkg::CR2_RESET;
      st_reg.cr3 <= ssa_pkg::CR3_RESET;
      st_reg.sync <= ssa_pkg::SYNC_RESET;
      st_reg.tx_out <= 1'b1;
      st_reg.rx_sh <= 8'hFF;
      st_reg.rx_st <= ssa_pkg::RX_HUNT;
      st_reg.sm_out <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign tx_data_out = st_reg.tx_out;
  assign tx_underflow_out = st_reg.uf_pulse;
  assign sync_match_terminal_ready = st_reg.sm_out;
  assign irq_req = st_reg.irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_tx_hold;
    st_reg.cr1[ssa_pkg::CR1_TX_RST] |=> tx_data_out && !st_reg.tx_on;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx not held in reset");

  // the bit may be cleared on the very edge after, so availability is judged only while set
  property p_txrst_avail;
    st_reg.cr1[ssa_pkg::CR1_TX_RST] |=> tx_empty
      && (!st_reg.cr1[ssa_pkg::CR1_TX_RST] || !status[ssa_pkg::ST_TX_AVAIL]);
  endproperty
  a_txrst_avail: assert property (p_txrst_avail) else $error("tx reset left data");

  property p_cts;
    cts_s && !st_reg.cr1[ssa_pkg::CR1_TX_RST] |=> tx_data_out && !st_reg.tx_on;
  endproperty
  a_cts: assert property (p_cts) else $error("cts did not inhibit");

  property p_irq_rel;
    release_irq |=> !irq_req;
  endproperty
  a_irq_rel: assert property (p_irq_rel) else $error("irq not released");

  property p_rx_avail_irq;
    receive_available_flag && st_reg.cr1[ssa_pkg::CR1_RX_IE] && !release_irq |=> irq_req;
  endproperty
  a_rx_avail_irq: assert property (p_rx_avail_irq) else $error("rx data did not raise irq");

  property p_rx_ones;
    st_reg.cr1[ssa_pkg::CR1_RX_RST] |=> st_reg.rx_sh == 8'hFF && rx_empty;
  endproperty
  a_rx_ones: assert property (p_rx_ones) else $error("rx shifter not ones");

  property p_lsb;
    txc_fall && tx_run && st_reg.tx_on && st_reg.tx_cnt != tx_last
      |=> tx_data_out == $past(st_reg.tx_sh[1]);
  endproperty
  a_lsb: assert property (p_lsb) else $error("wrong bit order");

  property p_uf;
    txc_rise && tx_run && st_reg.tx_on && st_reg.tx_cnt == tx_last && tx_empty
      |=> st_reg.uf_st && tx_underflow_out == st_reg.cr2[ssa_pkg::CR2_TX_SYNC_UF];
  endproperty
  a_uf: assert property (p_uf) else $error("underflow not flagged");

  property p_apb;
    setup |=> pready ##1 !pready;
  endproperty
  a_apb: assert property (p_apb) else $error("apb answer timing");

  property p_push;
    rx_push && !rx_full && !st_reg.cr1[ssa_pkg::CR1_RX_RST] |=> receive_available_flag;
  endproperty
  a_push: assert property (p_push) else $error("rx word lost");

  c_sync1: cover property (st_reg.rx_st == ssa_pkg::RX_HUNT ##1 st_reg.rx_st == ssa_pkg::RX_SYNCED);
  c_wait2: cover property (st_reg.rx_st == ssa_pkg::RX_WAIT2 ##1 st_reg.rx_st == ssa_pkg::RX_SYNCED);
  c_uf: cover property ($rose(tx_underflow_out));
  c_perr: cover property (status[ssa_pkg::ST_PERR]);
endmodule : ssa_core

// File: ssa_link_peer.sv
`timescale 1ns/1ps
module ssa_link_peer (
  output logic tx_clk,
  input wire logic tx_data_out,
  output logic rx_clk,
  output logic rx_data_in
);
  // transmit clock runs free since the transmitter fills idle time itself
  initial begin
    tx_clk = 1'b0;
    rx_clk = 1'b0;
    rx_data_in = 1'b1;
    #37;
    forever #100 tx_clk = ~tx_clk;
  end
  logic cap [$];
  // bits change after the tx fall, so the rise sits mid-bit
  always @(posedge tx_clk) cap.push_back(tx_data_out);
  // receive clock only runs inside a frame; first sent is bits[0]
  task automatic send(input logic [31:0] bits, input int n);
    #13;
    for (int i = 0; i < n; i++) begin
      rx_data_in = bits[i];
      #100 rx_clk = 1'b1;
      #100 rx_clk = 1'b0;
    end
    rx_data_in = ~rx_data_in; // stale once the frame is over
  endtask : send
endmodule : ssa_link_peer

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err, tx_clk, tx_data_out, clear_to_send_n, rx_clk, rx_data_in;
  logic carrier_detect_in_n, sync_match_terminal_ready, tx_underflow_out, irq_req;
  int n_fail = 0;
  int tests_run = 0;
  logic uf_seen = 1'b0;

  ssa_core ssa_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_clk(tx_clk), .tx_data_out(tx_data_out),
    .clear_to_send_n(clear_to_send_n), .rx_clk(rx_clk), .rx_data_in(rx_data_in),
    .carrier_detect_in_n(carrier_detect_in_n),
    .sync_match_terminal_ready(sync_match_terminal_ready),
    .tx_underflow_out(tx_underflow_out), .irq_req(irq_req));
  ssa_link_peer ssa_link_peer_i (.tx_clk(tx_clk), .tx_data_out(tx_data_out),
    .rx_clk(rx_clk), .rx_data_in(rx_data_in));

  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;

  // the underflow pulse lasts half a link bit, so it is latched for a later check
  always @(posedge pclk) begin
    if (tx_underflow_out === 1'b1) uf_seen <= 1'b1;
  end

  ////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [8:0] fr(input logic [7:0] b);
    return {^b, b};
  endfunction : fr

  // looks for a bit pattern, first bit in pat[0], in the captured line
  function automatic logic seen(input logic [35:0] pat, input int n);
    logic [35:0] win;
    win = '0;
    foreach (ssa_link_peer_i.cap[i]) begin
      win = {ssa_link_peer_i.cap[i], win[35:1]};
      if (((win >> (36 - n)) & ((36'h1 << n) - 36'h1)) === pat) return 1'b1;
    end
    return 1'b0;
  endfunction : seen

  ////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_fail++;
    results();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    clear_to_send_n = 1'b0;
    carrier_detect_in_n = 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ssa_pkg::ADDR_CTRL, 8'h00);
    chk(rd[1:0], 32'h0);
    chk(tx_data_out, 32'h1);
    chk(irq_req, 32'h0);
    apb(1'b0, 12'h008, 8'h00);
    chk(err, 32'h1);
    // even parity, sync code as fill, one-sync receive
    apb(1'b1, ssa_pkg::ADDR_CTRL, 8'h03);
    apb(1'b1, ssa_pkg::ADDR_DATA, 8'h05);
    apb(1'b1, ssa_pkg::ADDR_CTRL, 8'h43);
    apb(1'b1, ssa_pkg::ADDR_DATA, 8'h02);
    apb(1'b1, ssa_pkg::ADDR_CTRL, 8'h83);
    apb(1'b1, ssa_pkg::ADDR_DATA, 8'h96);
    repeat (100) @(posedge pclk);
    chk(tx_data_out, 32'h1);
    ssa_link_peer_i.cap.delete();
    apb(1'b1, ssa_pkg::ADDR_CTRL, 8'hE0);
    repeat (240) @(posedge pclk);
    chk(seen(36'(fr(8'h96)), 9), 32'h1);
    chk(sync_match_terminal_ready, 32'h1);
    chk(uf_seen, 32'h1);
    apb(1'b0, ssa_pkg::ADDR_CTRL, 8'h00);
    chk(rd[ssa_pkg::ST_TX_AVAIL], 32'h1);
    chk(rd[ssa_pkg::ST_UF], 32'h1);
    chk(irq_req, 32'h0);
    // four back-to-back bytes: at most one can leave before status is read
    apb(1'b1, ssa_pkg::ADDR_DATA, 8'hA5);
    apb(1'b1, ssa_pkg::ADDR_DATA, 8'h3D);
    apb(1'b1, ssa_pkg::ADDR_DATA, 8'h5A);
    apb(1'b1, ssa_pkg::ADDR_DATA, 8'hC3);
    apb(1'b0, ssa_pkg::ADDR_CTRL, 8'h00);
    chk(rd[ssa_pkg::ST_TX_AVAIL], 32'h0);
    repeat (600) @(posedge pclk);
    chk(seen(36'({fr(8'h5A), fr(8'h3D), fr(8'hA5)}), 27), 32'h1);
    clear_to_send_n <= 1'b1;
    repeat (10) @(posedge pclk);
    ssa_link_peer_i.cap.delete();
    repeat (200) @(posedge pclk);
    chk(seen(36'h0, 1), 32'h0);
    apb(1'b0, ssa_pkg::ADDR_CTRL, 8'h00);
    chk(rd[ssa_pkg::ST_CTS], 32'h1);
    clear_to_send_n <= 1'b0;
    // idle ones, sync, good byte, byte with wrong parity
    ssa_link_peer_i.send({~(^8'h5A), 8'h5A, fr(8'h3D), 8'h96, 4'hF}, 30);
    repeat (40) @(posedge pclk);
    chk(irq_req, 32'h1);
    apb(1'b0, ssa_pkg::ADDR_CTRL, 8'h00);
    chk({rd[ssa_pkg::ST_PERR], rd[ssa_pkg::ST_RX_AVAIL]}, 32'h1);
    apb(1'b0, ssa_pkg::ADDR_DATA, 8'h00);
    chk(rd, 32'h3D);
    apb(1'b0, ssa_pkg::ADDR_CTRL, 8'h00);
    chk({rd[ssa_pkg::ST_PERR], rd[ssa_pkg::ST_RX_AVAIL]}, 32'h3);
    apb(1'b0, ssa_pkg::ADDR_DATA, 8'h00);
    chk(rd, 32'h5A);
    apb(1'b0, ssa_pkg::ADDR_CTRL, 8'h00);
    chk(rd[ssa_pkg::ST_RX_AVAIL], 32'h0);
    chk(irq_req, 32'h0);
    results();
  end
endmodule : tb_top
